// >>> mpa_defines.vh
// Constants for the multifunction pin assignment block
// Summary of operation
// - Printer mode: all eight parallel data pins form a bidirectional byte bus.
// - Floppy extension modes: data bits 1-4 are pulled-up drive status inputs.
// - Single-drive mode serves external drive B; dual-drive mode serves A and B.
// - Data bit 5 is left undriven in both floppy extension modes.
// - Data bit 6: undriven single-drive, open-drain drive A motor-on in dual-drive.
// - Data bit 7: undriven single-drive, open-drain drive A select in dual-drive.
// - Port A request-to-send strap loads config 26 bit 6; high selects 4Eh.
// - Port A terminal-ready strap loads config 24 bit 0; high clears default resources.
// - Port A transmit strap loads config 24 bit 1, the flash enable; low enables the flash.
// - Port B transmit strap loads config 24 bit 6, input clock select.
// - Strap pins are pulled low during power-on reset; unstrapped reads zero.
// - Port A and B clear-to-send inputs are readable in handshake status bit 4.
// - Request-to-send and terminal-ready outputs go low to signal readiness.
// - Port C eight pins double as GPIO port 6 bits 7 down to 0.
// - Infrared receive and transmit alternate with GPIO port 3 bits 6 and 7.
// - Flash 19-bit address shares pins with GPIO ports 5, 4 and 3.
// - Flash data shares GPIO port 2; select and strobes share port 5 bits 2-0.
// - Watchdog output is open drain on GPIO 8 bit 0; port D receive on 7 bit 3.
// - Configuration and strap bits reset only on cold reset, never on warm.
// - Config port is 2Eh when strap bit is 0, 4Eh when 1; enter with 87h twice.
`ifndef MPA_DEFINES_VH
`define MPA_DEFINES_VH
`define MPA_OFF_CTRL 8'h00
`define MPA_OFF_CFG24 8'h04
`define MPA_OFF_CFG26 8'h08
`define MPA_OFF_HS_A 8'h0C
`define MPA_OFF_HS_B 8'h10
`define MPA_OFF_CFGPORT 8'h14
`define MPA_OFF_STATUS 8'h18
`define MPA_CTRL_RST 8'h00
`define MPA_CFG_RST 8'h00
`define MPA_MODE_PRINTER 2'h0
`define MPA_MODE_EXT1 2'h1
`define MPA_MODE_EXT2 2'h2
`define MPA_CTRL_UARTC 2
`define MPA_CTRL_IR 3
`define MPA_CTRL_WDT 4
`define MPA_CTRL_UARTD 5
`define MPA_CFG24_CLRDEF 0
`define MPA_CFG24_FLASH 1
`define MPA_CFG24_CLK48 6
`define MPA_CFG26_PORTSEL 6
`define MPA_HS_CTS 4
`define MPA_CFGPORT_LO 8'h2E
`define MPA_CFGPORT_HI 8'h4E
`define MPA_CFG_KEY 8'h87
`define MPA_STRAP_PORTSEL 0
`define MPA_STRAP_CLRDEF 1
`define MPA_STRAP_FLASH 2
`define MPA_STRAP_CLK48 3
`define MPA_STRAP_TIME_NS 200
`define MPA_CLK_PERIOD_NS 10
`define MPA_STRAP_CYCLES ((`MPA_STRAP_TIME_NS + `MPA_CLK_PERIOD_NS - 1) / `MPA_CLK_PERIOD_NS)
`define MPA_PAD_GP6 0
`define MPA_PAD_GP3 8
`define MPA_PAD_GP4 16
`define MPA_PAD_GP5 24
`define MPA_PAD_GP2 30
`define MPA_PAD_GPIO7_BIT3 38
`define MPA_PAD_GPIO8_BIT0 39
`define MPA_NPAD 40
`endif

// >>> mpa_sync.v
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module mpa_sync #(
	parameter W = 1,
	parameter [W-1:0] INIT = {W{1'b1}}
) (
	input wire clk,
	input wire rst_n,
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta_q;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= INIT;
			q <= INIT;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule // mpa_sync
`default_nettype wire

// >>> mpa_strap.v
// Power-on strap window timer and strap capture
`timescale 1ns/1ps
`default_nettype none
`include "mpa_defines.vh"
module mpa_strap #(
	parameter CYCLES = `MPA_STRAP_CYCLES
) (
	input wire clk,
	input wire rst_n,
	input wire [3:0] strap_sync,
	output reg busy_q,
	output reg load_q,
	output reg [3:0] value_q
);
	reg [15:0] cnt_q;
	// Pins are sampled at the close of the window, after the pull-downs settle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_q <= 1'b1;
			load_q <= 1'b0;
			value_q <= 4'h0;
			cnt_q <= 16'h0000;
		end else begin
			load_q <= 1'b0;
			if (busy_q) begin
				if (cnt_q == CYCLES[15:0] - 16'h0001) begin
					busy_q <= 1'b0;
					load_q <= 1'b1;
					value_q <= strap_sync;
				end else begin
					cnt_q <= cnt_q + 16'h0001;
				end
			end
		end
	end
endmodule // mpa_strap
`default_nettype wire

// >>> mpa_top.v
// Pin function multiplexer, strap capture and APB configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "mpa_defines.vh"
module mpa_top #(
	parameter NPAD = `MPA_NPAD
) (
	input wire pclk,
	input wire presetn,
	input wire warm_rst_n,
	input wire [7:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [7:0] par_data_i,
	output reg [7:0] par_data_o,
	output reg [7:0] par_data_oe,
	output reg [7:0] par_pullup_en,
	input wire [7:0] printer_do,
	input wire printer_doe,
	output reg [7:0] printer_di,
	output reg ext_track_zero_n,
	output reg ext_write_protect_n,
	output reg ext_read_data_n,
	output reg ext_disk_change_n,
	input wire ext_motor_a_on_n,
	input wire ext_drive_sel_a_n,
	output reg ext_drive_a_en,
	output reg ext_drive_b_en,
	input wire [3:0] strap_pin_i,
	output reg [3:0] strap_pin_o,
	output reg [3:0] strap_pin_oe,
	output reg strap_pulldown_en,
	input wire port_a_request_to_send_n,
	input wire port_a_terminal_ready_n,
	input wire port_a_tx,
	input wire port_b_tx,
	input wire port_a_clear_to_send_n,
	input wire port_b_clear_to_send_n,
	output reg cfg_port_select_strap,
	output reg clear_default_resources_strap,
	output reg flash_enable_strap,
	output reg input_clock_48_select,
	input wire [NPAD-1:0] pad_i,
	output reg [NPAD-1:0] pad_o,
	output reg [NPAD-1:0] pad_oe,
	input wire [NPAD-1:0] gpio_out,
	input wire [NPAD-1:0] gpio_oe,
	output reg [NPAD-1:0] gpio_in,
	input wire [2:0] uart_c_out,
	output reg port_c_clear_to_send_n,
	output reg port_c_ring_n,
	output reg [2:0] uart_c_in,
	input wire infrared_tx,
	output reg infrared_rx,
	input wire [18:0] flash_addr,
	input wire [7:0] flash_data_out,
	input wire flash_data_oe,
	input wire flash_chip_select_n,
	input wire flash_read_enable_n,
	input wire flash_write_enable_n,
	output reg [7:0] flash_data_in,
	input wire watchdog_timeout_out,
	output reg port_d_rx
);
	localparam SW = NPAD + 15;

	function is_fdd;
		input [1:0] mode;
		begin
			is_fdd = (mode == `MPA_MODE_EXT1) || (mode == `MPA_MODE_EXT2);
		end
	endfunction

	// All pin levels cross into pclk through one synchroniser bank
	wire [SW-1:0] sync_q;
	wire [NPAD-1:0] pad_s;
	wire [7:0] par_s;
	wire [3:0] strap_s;
	wire cts_a_s;
	wire cts_b_s;
	wire warm_s_n;
	mpa_sync #(.W(SW), .INIT({{(SW-5){1'b1}}, 4'h0, 1'b1})) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.d({pad_i, par_data_i, port_b_clear_to_send_n, port_a_clear_to_send_n, strap_pin_i, warm_rst_n}),
		.q(sync_q)
	);
	assign warm_s_n = sync_q[0];
	assign strap_s = sync_q[4:1];
	assign cts_a_s = sync_q[5];
	assign cts_b_s = sync_q[6];
	assign par_s = sync_q[14:7];
	assign pad_s = sync_q[SW-1:15];

	wire strap_busy;
	wire strap_load;
	wire [3:0] strap_val;
	mpa_strap u_strap (
		.clk(pclk),
		.rst_n(presetn),
		.strap_sync(strap_s),
		.busy_q(strap_busy),
		.load_q(strap_load),
		.value_q(strap_val)
	);

	// Configuration registers: presetn is the cold reset; warm_rst_n never touches them
	reg [7:0] ctrl_q;
	reg [7:0] cfg24_q;
	reg [7:0] cfg26_q;
	wire [1:0] par_mode = ctrl_q[1:0];
	wire wr_en = psel & penable & pready & pwrite;
	wire flash_on = ~cfg24_q[`MPA_CFG24_FLASH];

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `MPA_CTRL_RST;
			cfg24_q <= `MPA_CFG_RST;
			cfg26_q <= `MPA_CFG_RST;
		end else begin
			if (wr_en && paddr == `MPA_OFF_CTRL)
				ctrl_q <= pwdata[7:0];
			if (wr_en && paddr == `MPA_OFF_CFG24)
				cfg24_q <= pwdata[7:0];
			if (wr_en && paddr == `MPA_OFF_CFG26)
				cfg26_q <= pwdata[7:0];
			// Strap load beats a software write in the same cycle
			if (strap_load) begin
				cfg26_q[`MPA_CFG26_PORTSEL] <= strap_val[`MPA_STRAP_PORTSEL];
				cfg24_q[`MPA_CFG24_CLRDEF] <= strap_val[`MPA_STRAP_CLRDEF];
				cfg24_q[`MPA_CFG24_FLASH] <= strap_val[`MPA_STRAP_FLASH];
				cfg24_q[`MPA_CFG24_CLK48] <= strap_val[`MPA_STRAP_CLK48];
			end
		end
	end

	// APB slave: one wait-free access phase, pready raised from the setup cycle
	reg [31:0] rd_d;
	reg hit_d;
	always @* begin
		rd_d = 32'h00000000;
		hit_d = 1'b1;
		case (paddr)
			`MPA_OFF_CTRL: rd_d[7:0] = ctrl_q;
			`MPA_OFF_CFG24: rd_d[7:0] = cfg24_q;
			`MPA_OFF_CFG26: rd_d[7:0] = cfg26_q;
			`MPA_OFF_HS_A: rd_d[`MPA_HS_CTS] = ~cts_a_s;
			`MPA_OFF_HS_B: rd_d[`MPA_HS_CTS] = ~cts_b_s;
			`MPA_OFF_CFGPORT: begin
				rd_d[7:0] = cfg26_q[`MPA_CFG26_PORTSEL] ? `MPA_CFGPORT_HI : `MPA_CFGPORT_LO;
				rd_d[15:8] = `MPA_CFG_KEY;
			end
			`MPA_OFF_STATUS: rd_d[3:0] = {flash_on, ~warm_s_n, strap_busy, ~strap_busy};
			default: hit_d = 1'b0;
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			if (psel && !penable) begin
				pready <= 1'b1;
				pslverr <= ~hit_d;
				prdata <= pwrite ? 32'h00000000 : rd_d;
			end else begin
				pready <= 1'b0;
				pslverr <= 1'b0;
			end
		end
	end

	// Alternate-function drive and select for each shared pad
	reg [NPAD-1:0] alt_sel;
	reg [NPAD-1:0] alt_o;
	reg [NPAD-1:0] alt_oe;
	integer k;
	always @* begin
		alt_sel = {NPAD{1'b0}};
		alt_o = {NPAD{1'b0}};
		alt_oe = {NPAD{1'b0}};
		if (ctrl_q[`MPA_CTRL_UARTC]) begin
			alt_sel[`MPA_PAD_GP6 +: 8] = 8'hFF;
			alt_o[`MPA_PAD_GP6 + 5] = uart_c_out[2];
			alt_o[`MPA_PAD_GP6 + 4] = uart_c_out[1];
			alt_o[`MPA_PAD_GP6 + 2] = uart_c_out[0];
			alt_oe[`MPA_PAD_GP6 +: 8] = 8'h34;
		end
		if (flash_on) begin
			for (k = 0; k < 8; k = k + 1) begin
				alt_o[`MPA_PAD_GP3 + k] = flash_addr[k];
				alt_o[`MPA_PAD_GP4 + k] = flash_addr[8 + k];
				alt_o[`MPA_PAD_GP2 + k] = flash_data_out[k];
			end
			for (k = 0; k < 3; k = k + 1)
				alt_o[`MPA_PAD_GP5 + 3 + k] = flash_addr[16 + k];
			alt_o[`MPA_PAD_GP5 + 2] = flash_chip_select_n;
			alt_o[`MPA_PAD_GP5 + 1] = flash_read_enable_n;
			alt_o[`MPA_PAD_GP5 + 0] = flash_write_enable_n;
			alt_sel[`MPA_PAD_GP3 +: 30] = {30{1'b1}};
			alt_oe[`MPA_PAD_GP3 +: 22] = {22{1'b1}};
			alt_oe[`MPA_PAD_GP2 +: 8] = {8{flash_data_oe}};
		end
		// Infrared takes precedence over address bits 6 and 7 that it shares
		if (ctrl_q[`MPA_CTRL_IR]) begin
			alt_sel[`MPA_PAD_GP3 + 6] = 1'b1;
			alt_oe[`MPA_PAD_GP3 + 6] = 1'b0;
			alt_sel[`MPA_PAD_GP3 + 7] = 1'b1;
			alt_o[`MPA_PAD_GP3 + 7] = infrared_tx;
			alt_oe[`MPA_PAD_GP3 + 7] = 1'b1;
		end
		alt_sel[`MPA_PAD_GPIO7_BIT3] = ctrl_q[`MPA_CTRL_UARTD];
		// Open drain: only ever pulls low, released otherwise
		alt_sel[`MPA_PAD_GPIO8_BIT0] = ctrl_q[`MPA_CTRL_WDT];
		alt_oe[`MPA_PAD_GPIO8_BIT0] = ~watchdog_timeout_out;
	end

	// Pad outputs are registered; a warm reset releases every pad
	genvar g;
	generate
		for (g = 0; g < NPAD; g = g + 1) begin : g_pad
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pad_o[g] <= 1'b0;
					pad_oe[g] <= 1'b0;
					gpio_in[g] <= 1'b0;
				end else begin
					pad_o[g] <= alt_sel[g] ? alt_o[g] : gpio_out[g];
					pad_oe[g] <= warm_s_n & (alt_sel[g] ? alt_oe[g] : gpio_oe[g]);
					gpio_in[g] <= alt_sel[g] ? 1'b0 : pad_s[g];
				end
			end
		end
	endgenerate

	// Function-side inputs read their idle level when their pad is not routed
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_c_clear_to_send_n <= 1'b1;
			port_c_ring_n <= 1'b1;
			uart_c_in <= 3'h7;
			infrared_rx <= 1'b1;
			flash_data_in <= 8'h00;
			port_d_rx <= 1'b1;
		end else begin
			port_c_clear_to_send_n <= ctrl_q[`MPA_CTRL_UARTC] ? pad_s[`MPA_PAD_GP6 + 7] : 1'b1;
			port_c_ring_n <= ctrl_q[`MPA_CTRL_UARTC] ? pad_s[`MPA_PAD_GP6 + 0] : 1'b1;
			uart_c_in <= ctrl_q[`MPA_CTRL_UARTC] ? {pad_s[`MPA_PAD_GP6 + 6], pad_s[`MPA_PAD_GP6 + 3],
				pad_s[`MPA_PAD_GP6 + 1]} : 3'h7;
			infrared_rx <= ctrl_q[`MPA_CTRL_IR] ? pad_s[`MPA_PAD_GP3 + 6] : 1'b1;
			flash_data_in <= flash_on ? pad_s[`MPA_PAD_GP2 +: 8] : 8'h00;
			port_d_rx <= ctrl_q[`MPA_CTRL_UARTD] ? pad_s[`MPA_PAD_GPIO7_BIT3] : 1'b1;
		end
	end

	// Parallel data pins: printer bus or external floppy lines
	reg [7:0] par_o_d;
	reg [7:0] par_oe_d;
	reg [7:0] par_pu_d;
	always @* begin
		par_o_d = 8'h00;
		par_oe_d = 8'h00;
		par_pu_d = 8'h00;
		case (par_mode)
			`MPA_MODE_PRINTER: begin
				par_o_d = printer_do;
				par_oe_d = {8{printer_doe}};
			end
			`MPA_MODE_EXT1: begin
				par_pu_d = 8'h1F;
			end
			`MPA_MODE_EXT2: begin
				par_pu_d = 8'h1F;
				par_oe_d[6] = ~ext_motor_a_on_n;
				par_oe_d[7] = ~ext_drive_sel_a_n;
			end
			default: begin
				par_oe_d = 8'h00;
			end
		endcase
		// Bit 5 stays released in both extension modes
		if (is_fdd(par_mode))
			par_oe_d[5] = 1'b0;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			par_data_o <= 8'h00;
			par_data_oe <= 8'h00;
			par_pullup_en <= 8'h00;
			printer_di <= 8'h00;
			ext_track_zero_n <= 1'b1;
			ext_write_protect_n <= 1'b1;
			ext_read_data_n <= 1'b1;
			ext_disk_change_n <= 1'b1;
			ext_drive_a_en <= 1'b0;
			ext_drive_b_en <= 1'b0;
		end else begin
			par_data_o <= par_o_d;
			par_data_oe <= warm_s_n ? par_oe_d : 8'h00;
			par_pullup_en <= par_pu_d;
			printer_di <= (par_mode == `MPA_MODE_PRINTER) ? par_s : 8'h00;
			ext_track_zero_n <= is_fdd(par_mode) ? par_s[1] : 1'b1;
			ext_write_protect_n <= is_fdd(par_mode) ? par_s[2] : 1'b1;
			ext_read_data_n <= is_fdd(par_mode) ? par_s[3] : 1'b1;
			ext_disk_change_n <= is_fdd(par_mode) ? par_s[4] : 1'b1;
			ext_drive_a_en <= (par_mode == `MPA_MODE_EXT2);
			ext_drive_b_en <= is_fdd(par_mode);
		end
	end

	// Strap pins: released and pulled low in the window, then serial outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap_pin_o <= 4'hF;
			strap_pin_oe <= 4'h0;
			strap_pulldown_en <= 1'b1;
			cfg_port_select_strap <= 1'b0;
			clear_default_resources_strap <= 1'b0;
			flash_enable_strap <= 1'b0;
			input_clock_48_select <= 1'b0;
		end else begin
			strap_pulldown_en <= strap_busy;
			strap_pin_oe <= strap_busy ? 4'h0 : 4'hF;
			// Warm reset parks the modem lines at not-ready
			if (!warm_s_n)
				strap_pin_o <= 4'hF;
			else
				strap_pin_o <= {port_b_tx, port_a_tx, port_a_terminal_ready_n, port_a_request_to_send_n};
			cfg_port_select_strap <= cfg26_q[`MPA_CFG26_PORTSEL];
			clear_default_resources_strap <= cfg24_q[`MPA_CFG24_CLRDEF];
			flash_enable_strap <= cfg24_q[`MPA_CFG24_FLASH];
			input_clock_48_select <= cfg24_q[`MPA_CFG24_CLK48];
		end
	end
endmodule // mpa_top
`default_nettype wire

// >>> mpa_tb_chk.sv
// Assertion checker for the pin assignment block
`timescale 1ns/1ps
`default_nettype none
module mpa_tb_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic warm_rst_n,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] par_data_o,
	input wire logic [7:0] par_data_oe,
	input wire logic [7:0] par_pullup_en,
	input wire logic ext_motor_a_on_n,
	input wire logic ext_drive_sel_a_n,
	input wire logic ext_drive_a_en,
	input wire logic ext_drive_b_en,
	input wire logic [3:0] strap_pin_o,
	input wire logic [3:0] strap_pin_oe,
	input wire logic strap_pulldown_en,
	input wire logic port_a_request_to_send_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Modes are held a few cycles so register stages of the mode path cannot skew
	sequence dual_s;
		ext_drive_a_en && ext_drive_b_en;
	endsequence
	sequence single_s;
		ext_drive_b_en && !ext_drive_a_en;
	endsequence
	apb_ready_a: assert property (psel && !penable |=> pready)
		else $error("setup not answered");
	apb_idle_a: assert property (!(psel && !penable) |=> !pready)
		else $error("stray ready");
	apb_err_a: assert property (pready && paddr > 8'h18 |-> pslverr)
		else $error("unmapped access not refused");
	drive_pair_a: assert property (ext_drive_a_en |-> ext_drive_b_en)
		else $error("drive A served without B");
	ext_inputs_a: assert property (ext_drive_b_en [*2] |-> par_pullup_en[4:1] == 4'hF && par_data_oe[5:1] == 5'h00)
		else $error("status pins not released");
	single_float_a: assert property (single_s [*2] |-> par_data_oe[7:6] == 2'h0)
		else $error("bits 6 7 driven in single mode");
	motor_od_a: assert property (dual_s [*3] |-> !par_data_o[6] && par_data_oe[6] == !$past(ext_motor_a_on_n))
		else $error("motor line not open drain");
	select_od_a: assert property (dual_s [*3] |-> !par_data_o[7] && par_data_oe[7] == !$past(ext_drive_sel_a_n))
		else $error("select line not open drain");
	strap_pull_a: assert property ($rose(presetn) |-> strap_pulldown_en [*8])
		else $error("strap pull-down dropped early");
	strap_quiet_a: assert property (strap_pulldown_en |-> strap_pin_oe == 4'h0)
		else $error("strap pin driven in window");
	// Warm reset parks the line high three edges late; the request pin reaches the output one edge late
	strap_drive_a: assert property ($past(warm_rst_n, 3) && $past(strap_pin_oe[0]) && strap_pin_oe[0]
		|-> strap_pin_o[0] == $past(port_a_request_to_send_n))
		else $error("request line not passed");
endmodule // mpa_tb_chk
bind mpa_top mpa_tb_chk chk_inst (.*);
`default_nettype wire

// >>> mpa_tb_far.sv
// Far-side model of the parallel pins: external drive and printer
`timescale 1ns/1ps
`default_nettype none
module mpa_tb_far (
	input wire logic clk,
	input wire logic [7:0] par_data_o,
	input wire logic [7:0] par_data_oe,
	input wire logic [7:0] par_pullup_en,
	input wire logic drive_on,
	input wire logic [3:0] drive_status_n,
	input wire logic prn_oe,
	input wire logic [7:0] prn_data,
	output logic [7:0] par_data_i
);
	logic [7:0] last_q;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (par_data_oe[i])
				par_data_i[i] = par_data_o[i];
			else if (drive_on && i >= 1 && i <= 4)
				par_data_i[i] = drive_status_n[i - 1];
			else if (prn_oe)
				par_data_i[i] = prn_data[i];
			else if (par_pullup_en[i])
				par_data_i[i] = 1'b1;
			else
				par_data_i[i] = ~(last_q[i] === 1'b1); // Floating line must not look stable
		end
	end
	always_ff @(posedge clk)
		last_q <= par_data_i;
endmodule // mpa_tb_far
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the pin assignment block
`timescale 1ns/1ps
`default_nettype none
`include "mpa_defines.vh"
module testbench;
	logic pclk = 0, presetn = 0, warm_rst_n = 1, psel = 0, penable = 0, pwrite = 0, printer_doe = 0;
	logic ext_motor_a_on_n = 1, ext_drive_sel_a_n = 1, port_a_request_to_send_n = 1, port_a_terminal_ready_n = 1;
	logic port_a_tx = 1, port_b_tx = 1, port_a_clear_to_send_n = 1, port_b_clear_to_send_n = 1, infrared_tx = 0;
	logic flash_data_oe = 0, flash_chip_select_n = 1, flash_read_enable_n = 1, flash_write_enable_n = 1;
	logic watchdog_timeout_out = 1, prn_oe = 0;
	logic [7:0] paddr = 0, printer_do = 0, flash_data_out = 0;
	logic [31:0] pwdata = 0;
	logic [2:0] uart_c_out = 0;
	logic [3:0] board = 0;
	logic [3:0] pats [2] = '{4'h5, 4'hA};
	logic [18:0] flash_addr = 0;
	// Modem holds ring and clear-to-send low on the shared pads
	logic [39:0] pad_i = 40'hBFFFFFBF7E, gpio_out = 0, gpio_oe = 0;
	wire [31:0] prdata;
	wire [7:0] par_data_i, par_data_o, par_data_oe, par_pullup_en, printer_di, flash_data_in;
	wire [3:0] strap_pin_i, strap_pin_o, strap_pin_oe;
	wire [39:0] pad_o, pad_oe, gpio_in;
	wire [2:0] uart_c_in;
	wire pready, pslverr, ext_track_zero_n, ext_write_protect_n, ext_read_data_n, ext_disk_change_n;
	wire ext_drive_a_en, ext_drive_b_en, strap_pulldown_en, cfg_port_select_strap, clear_default_resources_strap;
	wire flash_enable_strap, input_clock_48_select, port_c_clear_to_send_n, port_c_ring_n, infrared_rx, port_d_rx;
	int miscompares = 0, comparisons = 0;
	// Board resistors set the strap levels while the pins are not driven
	assign strap_pin_i = (strap_pin_oe & strap_pin_o) | (~strap_pin_oe & board);
	mpa_top #(.NPAD(40)) mpa_top_inst (.*);
	mpa_tb_far mpa_tb_far_inst (.clk(pclk), .par_data_o, .par_data_oe, .par_pullup_en, .drive_on(ext_drive_b_en),
		.drive_status_n(4'h9), .prn_oe, .prn_data(8'h3C), .par_data_i);
	always #5 pclk = ~pclk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] x, input logic ex);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		chk(pslverr, ex);
		if (!w)
			chk(prdata, x);
	endtask
	task automatic finish_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		// Second pass is a cold reset in mid-run with the opposite strap pattern
		for (int k = 0; k < 2; k++) begin
			board <= pats[k];
			presetn <= 0;
			wt(2);
			presetn <= 1;
			wt(30);
			chk({input_clock_48_select, flash_enable_strap, clear_default_resources_strap, cfg_port_select_strap}, pats[k]);
			apb(0, `MPA_OFF_CFG24, 0, {pats[k][3], 4'h0, pats[k][2:1]}, 0);
			apb(0, `MPA_OFF_CFG26, 0, {pats[k][0], 6'h00}, 0);
			apb(0, `MPA_OFF_CFGPORT, 0, {8'h87, pats[k][0] ? 8'h4E : 8'h2E}, 0);
		end
		port_a_request_to_send_n <= 0;
		port_a_clear_to_send_n <= 0;
		wt(5);
		chk(strap_pin_o[0], 0);
		apb(0, `MPA_OFF_HS_A, 0, 32'h10, 0);
		apb(0, `MPA_OFF_HS_B, 0, 32'h0, 0);
		apb(1, 8'h1C, 32'hFF, 0, 1);
		apb(0, 8'h1C, 0, 0, 1);
		apb(1, `MPA_OFF_CFG26, 32'h40, 0, 0);
		warm_rst_n <= 0;
		wt(6);
		chk({strap_pin_oe, strap_pin_o, pad_oe[29:8]}, {8'hFF, 22'h000000});
		apb(0, `MPA_OFF_STATUS, 0, 32'hD, 0);
		warm_rst_n <= 1;
		wt(6);
		apb(0, `MPA_OFF_STATUS, 0, 32'h9, 0);
		apb(0, `MPA_OFF_CFG26, 0, 32'h40, 0);
		apb(0, `MPA_OFF_CFG24, 0, 32'h41, 0);
		apb(1, `MPA_OFF_CTRL, 32'h0, 0, 0);
		printer_do <= 8'hA5;
		printer_doe <= 1;
		wt(2);
		chk({par_data_oe, par_data_o}, 16'hFFA5);
		printer_doe <= 0;
		prn_oe <= 1;
		wt(5);
		chk({par_data_oe, printer_di}, 16'h003C);
		prn_oe <= 0;
		for (int m = 1; m < 3; m++) begin
			apb(1, `MPA_OFF_CTRL, m, 0, 0);
			wt(5);
			chk({ext_disk_change_n, ext_read_data_n, ext_write_protect_n, ext_track_zero_n}, 4'h9);
			chk({ext_drive_a_en, ext_drive_b_en, par_data_oe[5]}, {m == 2, 2'b10});
			ext_motor_a_on_n <= 0;
			ext_drive_sel_a_n <= 0;
			wt(2);
			chk(par_data_oe[7:6], {2{m == 2}});
			ext_motor_a_on_n <= 1;
			ext_drive_sel_a_n <= 1;
			wt(2);
			chk(par_data_oe[7:6], 0);
		end
		apb(1, `MPA_OFF_CTRL, 32'h3F, 0, 0);
		uart_c_out <= 3'h5;
		infrared_tx <= 1;
		watchdog_timeout_out <= 0;
		wt(5);
		chk({par_data_oe, par_pullup_en}, 0);
		chk({port_c_clear_to_send_n, port_c_ring_n, infrared_rx, port_d_rx, gpio_in[7]}, 0);
		chk({pad_o[5:4], pad_o[2], pad_o[15], pad_oe[39]}, 5'h17);
		apb(1, `MPA_OFF_CTRL, 32'h3, 0, 0);
		flash_addr <= 19'h5A5A5;
		flash_chip_select_n <= 0;
		flash_write_enable_n <= 0;
		flash_data_out <= 8'hC3;
		flash_data_oe <= 1;
		wt(5);
		chk({port_c_clear_to_send_n, port_c_ring_n, infrared_rx, port_d_rx, gpio_in[7:0], gpio_in[39:38]}, 14'h3DFA);
		chk(pad_o[37:8], {8'hC3, 3'h5, 3'h2, 16'hA5A5});
		chk(pad_oe[37:8], 30'h3FFFFFFF);
		chk(flash_data_in, 8'hFF);
		finish_test();
	end
	initial begin
		#100000;
		miscompares++;
		$display("Error at %0t: timeout", $time);
		finish_test();
	end
endmodule // testbench
`default_nettype wire
